// ==== design/pgs_pkg.sv ====
package pgs_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int TENTH_S_NS = 100_000_000;
    localparam int CLK_NS = 8;
    localparam int TENTH_CYC = TENTH_S_NS / CLK_NS;
    localparam logic [15:0] CLEAN_FWD_FREQ_RST = 16'h01f4;
    localparam logic [15:0] CLEAN_REV_FREQ_RST = 16'h012c;
    localparam logic [15:0] CLEAN_RAMP_RST = 16'h0064;
    localparam logic [15:0] CLEAN_RAMP_MAX = 16'h8ca0;
    localparam logic [15:0] CLEAN_DUR_RST = 16'h0032;
    localparam logic [15:0] CLEAN_DUR_MIN = 16'h000a;
    localparam logic [15:0] CLEAN_DUR_MAX = 16'h2710;
    localparam logic [15:0] CLEAN_PAUSE_RST = 16'h000a;
    localparam logic [6:0] CLEAN_CYC_RST = 7'h01;
    localparam logic [6:0] CLEAN_CYC_MAX = 7'h64;
    localparam logic [15:0] TEMP_FULL_RANGE = 16'h07d0;
    localparam int NUM_PUMPS = 4;
    localparam int DI_W = 8;
    localparam logic [7:0] FN_MAN_POLL = 8'h55;
    localparam logic [7:0] FN_CLEAN = 8'h56;
    localparam logic [7:0] FN_LOCK_BASE = 8'h68;
    localparam logic [3:0] A_SVC_EN = 4'h0;
    localparam logic [3:0] A_MODE = 4'h1;
    localparam logic [3:0] A_ROT = 4'h2;
    localparam logic [3:0] A_SOFT = 4'h3;
    localparam logic [3:0] A_FREEZE = 4'h4;
    localparam logic [3:0] A_CLEAN_F = 4'h5;
    localparam logic [3:0] A_CLEAN_T = 4'h6;
    localparam logic [3:0] A_CLEAN_D = 4'h7;
    localparam logic [3:0] A_DI_FN = 4'h8;
    localparam logic [3:0] A_STATUS = 4'h9;
    localparam logic [3:0] A_SEG = 4'ha;
    typedef enum logic [2:0] {
        PGS_STOP = 3'b000, PGS_RUN = 3'b001, PGS_POLL_ADD = 3'b011,
        PGS_POLL_RED = 3'b010, PGS_CLEAN = 3'b110, PGS_FREEZE = 3'b111,
        PGS_HOLD = 3'b101
    } pgs_state_t;
    typedef enum logic [1:0] {
        PGS_CL_FWD = 2'b00, PGS_CL_P1 = 2'b01, PGS_CL_REV = 2'b11, PGS_CL_P2 = 2'b10
    } pgs_clph_t;
endpackage : pgs_pkg

// ==== design/pgs_top.sv ====
`timescale 1ns/10ps
module pgs_top
    import pgs_pkg::*;
#(
    parameter int TICK_CYC = TENTH_CYC
) (
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic [DI_W-1:0] DI_I,
    input wire logic START_I,
    input wire logic STOP_I,
    input wire logic [15:0] FEEDBACK_I,
    input wire logic [15:0] PID_FREQ_I,
    input wire logic [15:0] TEMP_RAW_I,
    input wire logic [1:0] SEGMENT_I,
    input wire logic SEGMENT_VALID_I,
    input wire logic PUMP_STEP_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    output logic [NUM_PUMPS-1:0] RELAY_O,
    output logic [15:0] FREQ_SET_O,
    output logic [15:0] RAMP_TIME_O,
    output logic REVERSE_O,
    output logic MOTOR_RUN_O,
    output logic FREEZE_O,
    output logic [15:0] PRESSURE_REF_O,
    output logic [15:0] TEMP_O
);
    typedef struct packed {
        logic [DI_W-1:0] di_m;
        logic [DI_W-1:0] di_s;
        logic [2:0] cmd_m;
        logic [2:0] cmd_s;
        logic [2:0] cmd_d;
        logic svc_en;
        logic mode;
        logic [15:0] rot_cycle;
        logic [15:0] rot_thr;
        logic soft_en;
        logic [15:0] soft_freq;
        logic [15:0] soft_time;
        logic [15:0] soft_cut;
        logic frz_en;
        logic [15:0] frz_thr;
        logic [15:0] frz_freq;
        logic [15:0] cl_ffreq;
        logic [15:0] cl_rfreq;
        logic [15:0] cl_framp;
        logic [15:0] cl_rramp;
        logic [15:0] cl_fdur;
        logic [15:0] cl_rdur;
        logic [15:0] cl_pause;
        logic [6:0] cl_cycles;
        logic [63:0] di_fn;
        logic [63:0] seg_p;
        logic [15:0] base_p;
        pgs_state_t st;
        pgs_clph_t ph;
        logic [6:0] cyc_cnt;
        logic [1:0] pump;
        logic [NUM_PUMPS-1:0] on;
        logic [1:0] vf;
        logic need_stop;
        logic frz_armed;
        logic soft_act;
        logic [31:0] tick;
        logic [15:0] tenths;
        logic [15:0] rot_tenths;
        logic [31:0] rdata;
        logic [NUM_PUMPS-1:0] relay;
        logic [15:0] freq;
        logic [15:0] ramp;
        logic rev;
        logic run;
        logic frz;
        logic [15:0] pref;
        logic [15:0] temp;
    } pgs_reg_t;

    pgs_reg_t r_ff;
    pgs_reg_t nxt_r;

    // true when any synchronised terminal carries the given function code
    function automatic logic pgs_fn_hit(input logic [63:0] fn, input logic [DI_W-1:0] di,
                                        input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DI_W; i++) begin
            if (di[i] && fn[i*8 +: 8] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : pgs_fn_hit

    logic [NUM_PUMPS-1:0] locked;
    genvar g;
    generate
        for (g = 0; g < NUM_PUMPS; g++) begin : g_lock
            assign locked[g] = pgs_fn_hit(r_ff.di_fn, r_ff.di_s,
                FN_LOCK_BASE + 8'(g));
        end
    endgenerate

    // first available pump at or above a start index, wrapping
    function automatic logic [2:0] pgs_next_free(input logic [NUM_PUMPS-1:0] busy,
                                                 input logic [1:0] from);
        logic [2:0] res;
        logic [1:0] idx;
        res = 3'h4;
        for (int k = NUM_PUMPS - 1; k >= 0; k--) begin
            idx = from + 2'(k);
            if (!busy[idx]) begin
                res = {1'b0, idx};
            end
        end
        return res;
    endfunction : pgs_next_free

    always_comb begin
        logic start_ev;
        logic stop_ev;
        logic step;
        logic sec_tick;
        logic [15:0] phase_len;
        logic [2:0] nf;
        logic [2:0] nf2;
        nxt_r = r_ff;
        nxt_r.di_m = DI_I;
        nxt_r.di_s = r_ff.di_m;
        nxt_r.cmd_m = {PUMP_STEP_I, STOP_I, START_I};
        nxt_r.cmd_s = r_ff.cmd_m;
        nxt_r.cmd_d = r_ff.cmd_s;
        // start and step as rising edges, stop as a level, judged on synchronised samples only
        start_ev = r_ff.cmd_s[0] && !r_ff.cmd_d[0];
        stop_ev = r_ff.cmd_s[1];
        step = r_ff.cmd_s[2] && !r_ff.cmd_d[2];
        nxt_r.rdata = 32'h0;
        sec_tick = (r_ff.tick == 32'(TICK_CYC - 1));
        nxt_r.tick = sec_tick ? 32'h0 : r_ff.tick + 32'h1;
        nf = 3'h4;
        nf2 = 3'h4;
        phase_len = r_ff.cl_pause;
        if (WR_I) begin
            if (ADDR_I == A_SVC_EN) begin
                nxt_r.svc_en = WDATA_I[0];
            end else if (ADDR_I == A_MODE) begin
                nxt_r.mode = WDATA_I[0];
            end else if (ADDR_I == A_ROT) begin
                nxt_r.rot_cycle = WDATA_I[15:0];
                nxt_r.rot_thr = WDATA_I[31:16];
            end else if (ADDR_I == A_SOFT) begin
                nxt_r.soft_en = WDATA_I[0];
                nxt_r.soft_freq = {6'h0, WDATA_I[10:1]};
                nxt_r.soft_time = {6'h0, WDATA_I[20:11]};
                nxt_r.soft_cut = {5'h0, WDATA_I[31:21]};
            end else if (ADDR_I == A_FREEZE) begin
                nxt_r.frz_en = WDATA_I[0];
                nxt_r.frz_thr = {1'b0, WDATA_I[15:1]};
                nxt_r.frz_freq = WDATA_I[31:16];
            end else if (ADDR_I == A_CLEAN_F) begin
                nxt_r.cl_ffreq = WDATA_I[15:0];
                nxt_r.cl_rfreq = WDATA_I[31:16];
            end else if (ADDR_I == A_CLEAN_T) begin
                nxt_r.cl_framp = (WDATA_I[15:0] > CLEAN_RAMP_MAX) ? CLEAN_RAMP_MAX
                                 : WDATA_I[15:0];
                nxt_r.cl_rramp = (WDATA_I[31:16] > CLEAN_RAMP_MAX) ? CLEAN_RAMP_MAX
                                 : WDATA_I[31:16];
            end else if (ADDR_I == A_CLEAN_D) begin
                nxt_r.cl_fdur = (WDATA_I[13:0] < 14'(CLEAN_DUR_MIN)) ? CLEAN_DUR_MIN
                    : (WDATA_I[13:0] > 14'(CLEAN_DUR_MAX)) ? CLEAN_DUR_MAX
                    : {2'h0, WDATA_I[13:0]};
                nxt_r.cl_rdur = (WDATA_I[27:14] < 14'(CLEAN_DUR_MIN)) ? CLEAN_DUR_MIN
                    : (WDATA_I[27:14] > 14'(CLEAN_DUR_MAX)) ? CLEAN_DUR_MAX
                    : {2'h0, WDATA_I[27:14]};
            end else if (ADDR_I == A_DI_FN) begin
                nxt_r.di_fn = {WDATA_I, r_ff.di_fn[63:32]};
            end else if (ADDR_I == A_SEG) begin
                nxt_r.seg_p = {WDATA_I, r_ff.seg_p[63:32]};
            end else if (ADDR_I == A_STATUS) begin
                nxt_r.cl_pause = (WDATA_I[13:0] < 14'(CLEAN_DUR_MIN)) ? CLEAN_DUR_MIN
                    : (WDATA_I[13:0] > 14'(CLEAN_DUR_MAX)) ? CLEAN_DUR_MAX
                    : {2'h0, WDATA_I[13:0]};
                nxt_r.cl_cycles = (WDATA_I[22:16] == 7'h0) ? 7'h1
                    : (WDATA_I[22:16] > CLEAN_CYC_MAX) ? CLEAN_CYC_MAX : WDATA_I[22:16];
                nxt_r.base_p = {8'h0, WDATA_I[31:24]};
            end
        end
        if (RD_I) begin
            if (ADDR_I == A_SVC_EN) begin
                nxt_r.rdata = {31'h0, r_ff.svc_en};
            end else if (ADDR_I == A_MODE) begin
                nxt_r.rdata = {31'h0, r_ff.mode};
            end else if (ADDR_I == A_ROT) begin
                nxt_r.rdata = {r_ff.rot_thr, r_ff.rot_cycle};
            end else if (ADDR_I == A_CLEAN_F) begin
                nxt_r.rdata = {r_ff.cl_rfreq, r_ff.cl_ffreq};
            end else if (ADDR_I == A_CLEAN_T) begin
                nxt_r.rdata = {r_ff.cl_rramp, r_ff.cl_framp};
            end else if (ADDR_I == A_CLEAN_D) begin
                nxt_r.rdata = {4'h0, r_ff.cl_rdur[13:0], r_ff.cl_fdur[13:0]};
            end else if (ADDR_I == A_STATUS) begin
                nxt_r.rdata = {9'h0, r_ff.cyc_cnt, r_ff.need_stop, r_ff.frz_armed,
                               r_ff.frz, r_ff.soft_act, r_ff.on, r_ff.pump, r_ff.vf,
                               1'b0, r_ff.st};
            end
        end
        // temperature readout
        nxt_r.temp = (TEMP_RAW_I > TEMP_FULL_RANGE) ? 16'h0 : TEMP_RAW_I;
        nxt_r.pref = (SEGMENT_VALID_I) ? r_ff.seg_p[SEGMENT_I*16 +: 16]
                     : r_ff.base_p;
        if (r_ff.temp > r_ff.frz_thr) begin
            nxt_r.frz_armed = 1'b1;
        end
        if (sec_tick) begin
            nxt_r.tenths = r_ff.tenths + 16'h1;
            nxt_r.rot_tenths = r_ff.rot_tenths + 16'h1;
        end
        if (stop_ev) begin
            nxt_r.need_stop = 1'b0;
        end
        case (r_ff.st)
            PGS_STOP: begin
                nxt_r.on = '0;
                if (r_ff.frz_en && r_ff.frz_armed && r_ff.temp < r_ff.frz_thr && !stop_ev) begin
                    nxt_r.st = PGS_FREEZE;
                end
                if (start_ev && r_ff.svc_en) begin
                    nxt_r.pump = 2'h0;
                    nxt_r.tenths = 16'h0;
                    nxt_r.rot_tenths = 16'h0;
                    if (pgs_fn_hit(r_ff.di_fn, r_ff.di_s, FN_MAN_POLL)) begin
                        if (!r_ff.need_stop) begin
                            nxt_r.st = PGS_POLL_ADD;
                        end
                    end else if (pgs_fn_hit(r_ff.di_fn, r_ff.di_s, FN_CLEAN)) begin
                        if (!r_ff.need_stop) begin
                            nxt_r.st = PGS_CLEAN;
                            nxt_r.ph = PGS_CL_FWD;
                            nxt_r.cyc_cnt = 7'h0;
                        end
                    end else begin
                        nxt_r.st = PGS_RUN;
                        nxt_r.soft_act = r_ff.soft_en;
                        nxt_r.on = '0;
                        nxt_r.vf = 2'h0;
                    end
                end
            end
            PGS_POLL_ADD: begin
                if (step) begin
                    nf = pgs_next_free(r_ff.on | locked, r_ff.pump);
                    if (nf[2]) begin
                        nxt_r.st = PGS_POLL_RED;
                        nxt_r.pump = 2'h0;
                    end else begin
                        nxt_r.on[nf[1:0]] = 1'b1;
                        nxt_r.pump = nf[1:0] + 2'h1;
                        // the step that fills the last pump ends adding: no relay
                        // moves afterwards, so no further step would come
                        if (pgs_next_free(nxt_r.on | locked, 2'h0) == 3'h4) begin
                            nxt_r.st = PGS_POLL_RED;
                            nxt_r.pump = 2'h0;
                        end
                    end
                end
            end
            PGS_POLL_RED: begin
                if (step) begin
                    nf = pgs_next_free(~r_ff.on, r_ff.pump);
                    if (nf[2]) begin
                        nxt_r.st = PGS_HOLD;
                    end else begin
                        nxt_r.on[nf[1:0]] = 1'b0;
                        nxt_r.pump = nf[1:0] + 2'h1;
                    end
                end
            end
            PGS_CLEAN: begin
                nxt_r.on = '0;
                nxt_r.on[r_ff.pump] = 1'b1;
                case (r_ff.ph)
                    PGS_CL_FWD: phase_len = r_ff.cl_fdur;
                    PGS_CL_REV: phase_len = r_ff.cl_rdur;
                    default: phase_len = r_ff.cl_pause;
                endcase
                if (locked[r_ff.pump] || (sec_tick && r_ff.tenths + 16'h1 >= phase_len)) begin
                    nxt_r.tenths = 16'h0;
                    case (r_ff.ph)
                        PGS_CL_FWD: nxt_r.ph = PGS_CL_P1;
                        PGS_CL_P1: nxt_r.ph = PGS_CL_REV;
                        PGS_CL_REV: nxt_r.ph = PGS_CL_P2;
                        default: begin
                            nxt_r.ph = PGS_CL_FWD;
                            nxt_r.cyc_cnt = r_ff.cyc_cnt + 7'h1;
                        end
                    endcase
                    if (locked[r_ff.pump] || (r_ff.ph == PGS_CL_P2 &&
                        r_ff.cyc_cnt + 7'h1 >= r_ff.cl_cycles)) begin
                        nxt_r.ph = PGS_CL_FWD;
                        nxt_r.cyc_cnt = 7'h0;
                        if (r_ff.pump == 2'(NUM_PUMPS - 1)) begin
                            nxt_r.st = PGS_HOLD;
                        end else begin
                            nxt_r.pump = r_ff.pump + 2'h1;
                        end
                    end
                end
            end
            PGS_RUN: begin
                if (r_ff.soft_act && ((sec_tick && r_ff.tenths + 16'h1 >= r_ff.soft_time)
                    || FEEDBACK_I >= r_ff.soft_cut)) begin
                    nxt_r.soft_act = 1'b0;
                end
                if (r_ff.on == '0) begin
                    nf = pgs_next_free(locked, 2'h0);
                    if (!nf[2]) begin
                        nxt_r.on[nf[1:0]] = 1'b1;
                        nxt_r.vf = nf[1:0];
                    end
                end else if (r_ff.rot_cycle != 16'h0 && r_ff.rot_tenths >= r_ff.rot_cycle
                             && PID_FREQ_I < r_ff.rot_thr) begin
                    nf = pgs_next_free(r_ff.on | locked, r_ff.vf + 2'h1);
                    // mode 0 never drops the vf pump, only a running fixed-speed one
                    nf2 = r_ff.mode ? {1'b0, r_ff.vf} : pgs_next_free(
                        ~r_ff.on | (NUM_PUMPS'(1) << r_ff.vf), r_ff.vf + 2'h1);
                    nxt_r.rot_tenths = 16'h0;
                    if (!nf[2] && !nf2[2]) begin
                        nxt_r.on[nf[1:0]] = 1'b1;
                        nxt_r.on[nf2[1:0]] = 1'b0;
                        if (r_ff.mode) begin
                            nxt_r.vf = nf[1:0];
                        end
                    end
                end
                if (locked[r_ff.vf]) begin
                    nxt_r.on[r_ff.vf] = 1'b0;
                end
            end
            PGS_FREEZE: begin
                if (start_ev) begin
                    nxt_r.st = PGS_RUN;
                    nxt_r.soft_act = r_ff.soft_en;
                    nxt_r.on = '0;
                end
            end
            default: begin
                nxt_r.on = '0;
            end
        endcase
        if (stop_ev && r_ff.st != PGS_STOP) begin
            nxt_r.st = PGS_STOP;
            nxt_r.on = '0;
            if (r_ff.st == PGS_FREEZE) begin
                nxt_r.frz_armed = 1'b0;
            end
            nxt_r.need_stop = (r_ff.st == PGS_POLL_ADD) || (r_ff.st == PGS_POLL_RED)
                              || (r_ff.st == PGS_CLEAN);
        end
        if (r_ff.st == PGS_HOLD || ((r_ff.st == PGS_POLL_ADD || r_ff.st == PGS_POLL_RED
            || r_ff.st == PGS_CLEAN) && !stop_ev && nxt_r.st != r_ff.st)) begin
            nxt_r.need_stop = 1'b1;
        end
        if (r_ff.st == PGS_HOLD) begin
            nxt_r.st = stop_ev ? PGS_STOP : PGS_HOLD;
            nxt_r.need_stop = !stop_ev;
        end
        if (!r_ff.svc_en && r_ff.st != PGS_FREEZE) begin
            nxt_r.st = PGS_STOP;
            nxt_r.on = '0;
        end
        nxt_r.frz = (r_ff.st == PGS_FREEZE);
        nxt_r.run = (r_ff.st == PGS_RUN) || (r_ff.st == PGS_FREEZE)
                    || (r_ff.st == PGS_POLL_ADD) || (r_ff.st == PGS_POLL_RED)
                    || (r_ff.st == PGS_CLEAN && (r_ff.ph == PGS_CL_FWD
                        || r_ff.ph == PGS_CL_REV));
        nxt_r.rev = (r_ff.st == PGS_CLEAN) && (r_ff.ph == PGS_CL_REV);
        nxt_r.ramp = (r_ff.ph == PGS_CL_REV) ? r_ff.cl_rramp : r_ff.cl_framp;
        if (r_ff.st == PGS_FREEZE) begin
            nxt_r.freq = r_ff.frz_freq;
        end else if (r_ff.st == PGS_CLEAN) begin
            nxt_r.freq = (r_ff.ph == PGS_CL_REV) ? r_ff.cl_rfreq : r_ff.cl_ffreq;
        end else if (r_ff.st == PGS_RUN && r_ff.soft_act) begin
            nxt_r.freq = r_ff.soft_freq;
        end else if (r_ff.st == PGS_STOP || r_ff.st == PGS_HOLD) begin
            nxt_r.freq = 16'h0;
        end else begin
            nxt_r.freq = PID_FREQ_I;
        end
        // one relay per pump; mode 0 pins the vf pump to relay 0, mode 1 moves it
        nxt_r.relay = r_ff.on;
        if (!r_ff.mode && r_ff.st == PGS_RUN) begin
            nxt_r.vf = 2'h0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            r_ff <= '0;
            r_ff.svc_en <= 1'b1;
            r_ff.cl_ffreq <= CLEAN_FWD_FREQ_RST;
            r_ff.cl_rfreq <= CLEAN_REV_FREQ_RST;
            r_ff.cl_framp <= CLEAN_RAMP_RST;
            r_ff.cl_rramp <= CLEAN_RAMP_RST;
            r_ff.cl_fdur <= CLEAN_DUR_RST;
            r_ff.cl_rdur <= CLEAN_DUR_RST;
            r_ff.cl_pause <= CLEAN_PAUSE_RST;
            r_ff.cl_cycles <= CLEAN_CYC_RST;
            r_ff.frz_armed <= 1'b1;
            r_ff.st <= PGS_STOP;
            r_ff.ph <= PGS_CL_FWD;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign RDATA_O = r_ff.rdata;
    assign RELAY_O = r_ff.relay;
    assign FREQ_SET_O = r_ff.freq;
    assign RAMP_TIME_O = r_ff.ramp;
    assign REVERSE_O = r_ff.rev;
    assign MOTOR_RUN_O = r_ff.run;
    assign FREEZE_O = r_ff.frz;
    assign PRESSURE_REF_O = r_ff.pref;
    assign TEMP_O = r_ff.temp;
endmodule : pgs_top

// ==== verification/pgs_asserts.sv ====
`timescale 1ns/10ps
module pgs_asserts
    import pgs_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic STOP_I,
    input wire logic RD_I,
    input wire logic [15:0] TEMP_RAW_I,
    input wire logic [31:0] RDATA_O,
    input wire logic [NUM_PUMPS-1:0] RELAY_O,
    input wire logic REVERSE_O,
    input wire logic MOTOR_RUN_O,
    input wire logic FREEZE_O,
    input wire logic [15:0] TEMP_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence stop_held;
        STOP_I [*5];
    endsequence
    sequence raw_over;
        (TEMP_RAW_I > TEMP_FULL_RANGE) [*3];
    endsequence
    reset_quiet_a: assert property (!$past(ARST_N_I) |-> RELAY_O == '0 && !MOTOR_RUN_O)
        else $error("outputs active right after reset");
    rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == '0)
        else $error("read data without a read");
    temp_zero_a: assert property (raw_over |-> TEMP_O == '0)
        else $error("temperature not zero above full range");
    relay_step_a: assert property ($countones(RELAY_O & ~$past(RELAY_O)) <= 1)
        else $error("more than one pump closed at once");
    stop_halt_a: assert property (stop_held |-> !MOTOR_RUN_O && !REVERSE_O)
        else $error("motor runs while stop held");
    stop_thaw_a: assert property (stop_held |-> !FREEZE_O)
        else $error("freeze active while stop held");
    rev_runs_a: assert property (REVERSE_O |-> MOTOR_RUN_O)
        else $error("reverse without motor run");
    freeze_runs_a: assert property (FREEZE_O && $past(FREEZE_O) |-> MOTOR_RUN_O)
        else $error("freeze without motor run");
endmodule : pgs_asserts

// ==== verification/pgs_pump_model.sv ====
`timescale 1ns/10ps
module pgs_pump_model
    import pgs_pkg::*;
(
    input wire logic clk_i,
    input wire logic [NUM_PUMPS-1:0] relay_i,
    input wire logic run_i,
    input wire logic [7:0] dly_i,
    output logic step_o
);
    logic [NUM_PUMPS-1:0] relay_q = '0;
    logic run_q = 1'b0;
    logic [7:0] cnt = 8'h00;
    initial step_o = 1'b0;
    // contactor settles dly_i cycles after a coil change, then reports one step
    always @(posedge clk_i) begin
        relay_q <= relay_i;
        run_q <= run_i;
        step_o <= (cnt > 8'h00) && (cnt < 8'h05);
        if (relay_i != relay_q || (run_i && !run_q)) cnt <= dly_i + 8'h04;
        else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
endmodule : pgs_pump_model

// ==== verification/pgs_top_tb_top.sv ====
`timescale 1ns/10ps
module pgs_top_tb_top
    import pgs_pkg::*;
;
    logic clk = 1'b0, arst_n = 1'b0, start = 1'b0, stop = 1'b0, step, segv = 1'b0;
    logic wr_s = 1'b0, rd_s = 1'b0, rev, motor, frz;
    logic [7:0] di = '0, dly = 8'h08;
    logic [15:0] temp = 16'h01f4, pid = '0, fb = '0, fset, ramp, pref, temp_o;
    logic [1:0] seg = '0;
    logic [3:0] addr = '0, relay, first_on = '0, seen_on = '0;
    logic [31:0] wdata = '0, rdata, d;
    int n_errors = 0, total_checks = 0, n_rev = 0;
    always #4 clk = ~clk;
    pgs_top #(.TICK_CYC(10)) u_pgs_top (.REF_CLK_I(clk), .ARST_N_I(arst_n), .DI_I(di),
        .START_I(start), .STOP_I(stop), .FEEDBACK_I(fb), .PID_FREQ_I(pid),
        .TEMP_RAW_I(temp), .SEGMENT_I(seg), .SEGMENT_VALID_I(segv), .PUMP_STEP_I(step),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
        .RELAY_O(relay), .FREQ_SET_O(fset), .RAMP_TIME_O(ramp), .REVERSE_O(rev),
        .MOTOR_RUN_O(motor), .FREEZE_O(frz), .PRESSURE_REF_O(pref), .TEMP_O(temp_o));
    pgs_pump_model u_pgs_pump_model (.clk_i(clk), .relay_i(relay), .run_i(motor),
        .dly_i(dly), .step_o(step));
    always @(posedge clk) begin
        if (relay != '0 && first_on == '0) first_on <= relay;
        seen_on <= seen_on | relay;
        if ($rose(rev)) n_rev <= n_rev + 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : rd
    task automatic go;
        @(posedge clk);
        start <= 1'b1;
        tick(4);
        start <= 1'b0;
        tick(4);
    endtask : go
    task automatic halt;
        @(posedge clk);
        stop <= 1'b1;
        tick(6);
        stop <= 1'b0;
        tick(4);
    endtask : halt
    task automatic wait_cnt(input int k);
        for (int i = 0; i < 3000 && $countones(relay) != k; i++) @(posedge clk);
    endtask : wait_cnt
    task automatic clr;
        @(posedge clk);
        #1 first_on = '0;
        seen_on = '0;
        n_rev = 0;
    endtask : clr
    task automatic stop_test;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        tick(60000);
        n_errors++;
        stop_test();
    end
    initial begin
        tick(5);
        arst_n <= 1'b1;
        tick(3);
        rd(A_SVC_EN, d); chk(d, 32'h1);
        rd(A_MODE, d); chk(d, 32'h0);
        rd(A_CLEAN_F, d); chk(d, {CLEAN_REV_FREQ_RST, CLEAN_FWD_FREQ_RST});
        rd(A_CLEAN_T, d); chk(d, {CLEAN_RAMP_RST, CLEAN_RAMP_RST});
        rd(A_CLEAN_D, d); chk(d, {4'h0, CLEAN_DUR_RST[13:0], CLEAN_DUR_RST[13:0]});
        wr(A_CLEAN_T, 32'hffffffff);
        rd(A_CLEAN_T, d); chk(d, {CLEAN_RAMP_MAX, CLEAN_RAMP_MAX});
        wr(A_CLEAN_D, 32'h0);
        rd(A_CLEAN_D, d); chk(d, {4'h0, CLEAN_DUR_MIN[13:0], CLEAN_DUR_MIN[13:0]});
        rd(4'hf, d); chk(d, 32'h0);
        temp <= 16'h07d0; tick(4); chk(32'(temp_o), 32'h07d0);
        temp <= 16'h07d1; tick(4); chk(32'(temp_o), 32'h0);
        temp <= 16'h01f4;
        $display("test registers done");
        wr(A_DI_FN, 32'h00566955);
        wr(A_DI_FN, 32'h0);
        wr(A_SVC_EN, 32'h0);
        di <= 8'h01;
        go(); tick(50); chk(32'(relay), 32'h0);
        halt();
        wr(A_SVC_EN, 32'h1);
        clr(); go();
        wait_cnt(4); chk(32'(relay), 32'hf);
        wait_cnt(0); chk(32'(relay), 32'h0);
        chk(32'(first_on), 32'h1);
        go(); tick(100); chk(32'(relay), 32'h0);
        halt();
        di <= 8'h03;
        dly <= 8'h1e;
        clr(); go();
        wait_cnt(3); wait_cnt(0); chk(32'(seen_on), 32'hd);
        halt();
        di <= 8'h01;
        clr(); go();
        wait_cnt(2); halt(); chk(32'(motor), 32'h0);
        wait_cnt(0); chk(32'(relay), 32'h0);
        halt();
        $display("test polling done");
        wr(A_STATUS, {8'h00, 1'b0, 7'h01, 2'h0, 14'h000a});
        di <= 8'h04;
        clr(); go(); tick(20);
        chk({15'h0, rev, fset}, {16'h0, CLEAN_FWD_FREQ_RST});
        for (int i = 0; i < 3000 && rev !== 1'b1; i++) @(posedge clk);
        tick(2); chk({fset, ramp}, {CLEAN_REV_FREQ_RST, CLEAN_RAMP_MAX});
        for (int i = 0; i < 4000 && n_rev != 4; i++) @(posedge clk);
        tick(400); chk(n_rev, 4);
        chk({27'h0, motor, relay}, 32'h0);
        halt();
        di <= 8'h00;
        $display("test cleaning done");
        wr(A_FREEZE, {16'h0100, 15'h0064, 1'b1});
        temp <= 16'h0032; tick(10); chk({frz, fset}, {1'b1, 16'h0100});
        halt(); tick(20); chk(32'(frz), 32'h0);
        temp <= 16'h00c8; tick(10);
        temp <= 16'h0032; tick(10); chk(32'(frz), 32'h1);
        pid <= 16'h0123;
        go(); chk({frz, fset}, {1'b0, 16'h0123});
        tick(20); chk({frz, motor}, 2'b01);
        temp <= 16'h01f4;
        halt();
        $display("test freeze done");
        wr(A_MODE, 32'h1);
        wr(A_ROT, 32'h02000003);
        wr(A_SOFT, {11'h7ff, 10'h3ff, 10'h0aa, 1'b1});
        go(); chk(32'(fset), 32'h00aa);
        fb <= 16'h07ff; tick(30); chk(32'(fset), 32'h0123);
        chk(32'(relay), 32'h2);
        halt();
        wr(A_MODE, 32'h0);
        go(); tick(70); chk(32'(relay), 32'h1);
        halt();
        $display("test rotation done");
        wr(A_SEG, 32'h22221111);
        wr(A_SEG, 32'h44443333);
        segv <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            seg <= 2'(i);
            tick(5);
            chk(32'(pref), 32'(16'h1111 * (i + 1)));
        end
        $display("test segments done");
        stop_test();
    end
endmodule : pgs_top_tb_top
bind pgs_top pgs_asserts u_pgs_asserts (.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I),
    .STOP_I(STOP_I), .RD_I(RD_I), .TEMP_RAW_I(TEMP_RAW_I), .RDATA_O(RDATA_O),
    .RELAY_O(RELAY_O), .REVERSE_O(REVERSE_O), .MOTOR_RUN_O(MOTOR_RUN_O),
    .FREEZE_O(FREEZE_O), .TEMP_O(TEMP_O));
